// [pkg/pmb_pkg.sv]
// package: constants and carrier types for the parity memory bus slave
package pmb_pkg;
  localparam int ADDR_W       = 24;
  localparam int DATA_W       = 16;
  localparam int WORD_AW      = 18;
  localparam int IO_AW        = 16;
  localparam int KB_SHIFT     = 10;
  localparam int SEG_LSB      = 22;
  localparam int NUM_INT      = 8;
  localparam int INIT_CNT     = 18'h3FFFF;
  localparam int ACK_DLY_NS   = 40;
  localparam int CLK_NS       = 10;
  localparam int ACK_DLY_CYC  = (ACK_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] IO_WIDTH8  = 8'h08;
  localparam logic [7:0] IO_WIDTH12 = 8'h0C;
  localparam logic [1:0] SIZE_FULL  = 2'h1;
  localparam logic [1:0] SIZE_HALF  = 2'h0;
  localparam logic [3:0] PERR_RST   = 4'h0;

  typedef enum logic [1:0] {
    REF_ONBOARD = 2'b00,
    REF_OFF_ALWAYS = 2'b01,
    REF_OFF_WHEN_NOT_ONBOARD = 2'b10
  } pmb_ref_mode_t;

  typedef enum logic [2:0] {
    ST_INIT  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b011,
    ST_ACK   = 3'b100,
    ST_IOACK = 3'b101
  } pmb_state_t;

  typedef struct packed {
    logic [1:0]  seg;
    logic [13:0] low_kb;
    logic [13:0] high_kb;
    logic [1:0]  io_width;
    logic [4:0]  io_sel;
    logic        int_en;
    logic [2:0]  int_sel;
    pmb_ref_mode_t ref_mode;
    logic        offpar_en;
    logic        par_lo_drv;
    logic        par_hi_drv;
    logic        size_full;
  } pmb_cfg_t;

  typedef struct packed {
    logic        mrdc;
    logic        mwtc;
    logic        iorc;
    logic        iowc;
    logic        bhen;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } pmb_bus_t;

  typedef struct packed {
    logic       herr;
    logic       lerr;
    logic [1:0] bank;
  } pmb_perr_t;
endpackage : pmb_pkg

// [design/pmb_mem.sv]
// memory: parity word store with registered read data
`timescale 1ns/1ns
module pmb_mem #(
  parameter int AW = 18,
  parameter int DW = 18
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [1:0]    be,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  initial begin
    if (DW != 18) $error("pmb_mem needs two bytes plus two parity bits");
  end

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we && be[0]) begin
      mem[addr][8:0] <= wdata[8:0];
    end
    if (we && be[1]) begin
      mem[addr][17:9] <= wdata[17:9];
    end
    rdata <= mem[addr];
  end
endmodule : pmb_mem

// [design/pmb_slave.sv]
// top: bus slave of the parity memory expansion board
//
// Contract
// - init low ignores commands, clears memory
// - select from address bits 23 down to 10
// - window bounds in 1K steps
// - low 4K field from bits 15..12
// - high 64K field from bits 19..16
// - high 4K field from bits 15..12
// - high 1K field from bits 11..10
// - io decode 8/12/16 bits, upper zero
// - register at 00-0F or 40-4F
// - parity error drives one chosen interrupt
// - three refresh source modes
// - off-board parity enable and drive options
// - memory size 512K or 256K
// - even byte on low lanes
// - odd byte swapped to low lanes
// - word: even low, odd high
// - writes steer bytes, store with parity
// - acknowledge after write data taken
// - window held in one 4M segment
// - any io write to the register address clears register
// - latch failed byte and bank
// - upper bound is last used 1K
`timescale 1ns/1ns
module pmb_slave #(
  parameter int INIT_CYCLES = pmb_pkg::INIT_CNT
) (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RST,
  input  wire logic                      INIT_N,
  input  wire pmb_pkg::pmb_bus_t         BUS_IN,
  input  wire pmb_pkg::pmb_cfg_t         CFG,
  input  wire logic                      ONBOARD_REFRESH_INDICATION,
  input  wire logic                      OFFBOARD_PARITY_IN_N,
  output logic [pmb_pkg::DATA_W-1:0]     DAT_OUT,
  output logic                           DAT_OE_N,
  output logic                           XACK_OUT,
  output logic [pmb_pkg::NUM_INT-1:0]    INT_OUT,
  output logic                           OFFBOARD_REFRESH_REQUEST,
  output logic                           LOW_BYTE_PARITY_N,
  output logic                           HIGH_BYTE_PARITY_N,
  output logic [1:0]                     PAR_OE_N,
  output logic [3:0]                     PERR_REG
);
  initial begin
    if (INIT_CYCLES < 1 || INIT_CYCLES > 262143) $error("INIT_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronised bus inputs: three stages, accept when last two agree
  typedef struct packed {
    logic init_n;
    logic mrdc;
    logic mwtc;
    logic iorc;
    logic iowc;
    logic onref;
    logic offpar_n;
  } pmb_ctl_t;

  typedef struct packed {
    pmb_pkg::pmb_state_t       st;
    logic [17:0]               cnt;
    logic [2:0]                dly;
    pmb_ctl_t                  s1;
    pmb_ctl_t                  s2;
    pmb_ctl_t                  s3;
    pmb_ctl_t                  ctl;
    logic [pmb_pkg::DATA_W-1:0] dout;
    logic                      oe_n;
    logic                      xack;
    logic [pmb_pkg::NUM_INT-1:0] irq;
    logic                      ofref;
    logic                      p_lo_n;
    logic                      p_hi_n;
    logic [1:0]                p_oe_n;
    pmb_pkg::pmb_perr_t        perr;
    logic                      rd_pend;
    logic [1:0]                bank_use;
  } pmb_all_t;

  pmb_all_t r, n;

  logic [17:0] mem_rdata;
  logic [17:0] mem_wdata;
  logic [17:0] mem_addr;
  logic [1:0]  mem_be;
  logic        mem_we;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic odd_par(input logic [7:0] b);
    return ~^b;
  endfunction : odd_par

  function automatic logic in_window(input logic [23:0] a, input pmb_pkg::pmb_cfg_t c);
    logic [13:0] kb;
    kb = a[23:10];
    return (a[23:22] == c.seg)
        && ({c.seg, c.low_kb[11:0]} <= kb)
        && (kb <= {c.seg, c.high_kb[11:0]});
  endfunction : in_window

  function automatic logic io_hit(input logic [15:0] a, input pmb_pkg::pmb_cfg_t c);
    logic upper_zero;
    case (c.io_width)
      2'h0:    upper_zero = (a[7] == 1'b0) && (a[5:4] == 2'h0);
      2'h1:    upper_zero = (a[11:7] == 5'h00) && (a[5:4] == 2'h0);
      default: upper_zero = (a[15:7] == 9'h000) && (a[5:4] == 2'h0);
    endcase
    return upper_zero && (a[6] == c.io_sel[4]) && (a[3:0] == c.io_sel[3:0]);
  endfunction : io_hit

  ////////////////////////////////////////////////////////////////////////////
  // memory port: word address, byte lanes, parity bits
  logic [23:0] win_off;
  logic        odd_only;
  logic        word_xfer;
  logic [7:0]  wr_lo;
  logic [7:0]  wr_hi;

  always_comb begin
    win_off   = BUS_IN.adr - {CFG.seg, CFG.low_kb[11:0], 10'h000};
    word_xfer = BUS_IN.bhen && BUS_IN.adr[0];
    odd_only  = !BUS_IN.bhen && BUS_IN.adr[0];
    wr_lo     = BUS_IN.dat[7:0];
    wr_hi     = word_xfer ? BUS_IN.dat[15:8] : BUS_IN.dat[7:0];
    if (CFG.size_full) begin
      mem_addr = win_off[18:1];
    end else begin
      mem_addr = {1'b0, win_off[17:1]};
    end
    if (word_xfer) begin
      mem_be = 2'b11;
    end else if (odd_only) begin
      mem_be = 2'b10;
    end else begin
      mem_be = 2'b01;
    end
    mem_wdata = {odd_par(wr_hi), wr_hi, odd_par(wr_lo), wr_lo};
    mem_we    = (r.st == pmb_pkg::ST_WRITE) && (r.dly == 3'h0);
    if (r.st == pmb_pkg::ST_INIT) begin
      mem_addr  = r.cnt;
      mem_be    = 2'b11;
      mem_wdata = 18'h00000;
      mem_we    = 1'b1;
    end
  end

  pmb_mem #(.AW(18), .DW(18)) u_mem (
    .clk  (CORE_CLK),
    .we   (mem_we),
    .be   (mem_be),
    .addr (mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic lo_bad;
  logic hi_bad;
  logic use_lo;
  logic use_hi;
  logic mem_sel;
  logic io_sel;

  always_comb begin
    n = r;
    n.s1 = '{INIT_N, BUS_IN.mrdc, BUS_IN.mwtc, BUS_IN.iorc, BUS_IN.iowc,
             ONBOARD_REFRESH_INDICATION, OFFBOARD_PARITY_IN_N};
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.ctl = r.s3;
    end
    mem_sel = in_window(BUS_IN.adr, CFG);
    io_sel  = io_hit(BUS_IN.adr[15:0], CFG);
    use_lo  = !BUS_IN.adr[0] || BUS_IN.bhen;
    use_hi  = BUS_IN.adr[0];
    lo_bad  = use_lo && (mem_rdata[8] != odd_par(mem_rdata[7:0]));
    hi_bad  = use_hi && (mem_rdata[17] != odd_par(mem_rdata[16:9]));
    if (CFG.offpar_en && !r.ctl.offpar_n) begin
      lo_bad = use_lo;
    end
    n.bank_use = mem_addr[17:16];

    // refresh source selection
    case (CFG.ref_mode)
      pmb_pkg::REF_OFF_ALWAYS:           n.ofref = 1'b1;
      pmb_pkg::REF_OFF_WHEN_NOT_ONBOARD: n.ofref = !r.ctl.onref;
      default:                           n.ofref = 1'b0;
    endcase

    n.p_oe_n = {!(CFG.offpar_en && CFG.par_hi_drv), !(CFG.offpar_en && CFG.par_lo_drv)};
    n.p_lo_n = !(mem_rdata[8]);
    n.p_hi_n = !(mem_rdata[17]);

    case (r.st)
      pmb_pkg::ST_INIT: begin
        n.cnt = r.cnt + 18'h00001;
        if (r.cnt >= 18'(INIT_CYCLES)) begin
          n.cnt = 18'h00000;
          n.st  = pmb_pkg::ST_IDLE;
        end
      end
      pmb_pkg::ST_IDLE: begin
        n.dly = 3'(pmb_pkg::ACK_DLY_CYC);
        if (r.ctl.mwtc && mem_sel) begin
          n.st = pmb_pkg::ST_WRITE;
        end else if (r.ctl.mrdc && mem_sel) begin
          n.st = pmb_pkg::ST_READ;
        end else if ((r.ctl.iowc || r.ctl.iorc) && io_sel) begin
          if (r.ctl.iowc) begin
            n.perr = pmb_pkg::PERR_RST;
          end else begin
            n.dout = {12'h000, r.perr};
            n.oe_n = 1'b0;
          end
          n.st = pmb_pkg::ST_IOACK;
        end
      end
      pmb_pkg::ST_WRITE: begin
        if (r.dly != 3'h0) begin
          n.dly = r.dly - 3'h1;
        end else begin
          n.xack = 1'b1;
          n.st   = pmb_pkg::ST_ACK;
        end
      end
      pmb_pkg::ST_READ: begin
        if (r.dly != 3'h0) begin
          n.dly = r.dly - 3'h1;
        end else if (!r.rd_pend) begin
          n.rd_pend = 1'b1;
        end else begin
          n.rd_pend = 1'b0;
          if (word_xfer) begin
            n.dout = {mem_rdata[16:9], mem_rdata[7:0]};
          end else if (odd_only) begin
            n.dout = {8'h00, mem_rdata[16:9]};
          end else begin
            n.dout = {8'h00, mem_rdata[7:0]};
          end
          n.oe_n = 1'b0;
          if ((lo_bad || hi_bad) && !r.perr.lerr && !r.perr.herr) begin
            n.perr = '{hi_bad, lo_bad, mem_addr[17:16]};
          end
          n.st = pmb_pkg::ST_IOACK;
        end
      end
      pmb_pkg::ST_IOACK: begin
        n.xack = 1'b1;
        n.st   = pmb_pkg::ST_ACK;
      end
      pmb_pkg::ST_ACK: begin
        if (!r.ctl.mrdc && !r.ctl.mwtc && !r.ctl.iorc && !r.ctl.iowc) begin
          n.xack = 1'b0;
          n.oe_n = 1'b1;
          n.dout = 16'h0000;
          n.st   = pmb_pkg::ST_IDLE;
        end
      end
      default: n.st = pmb_pkg::ST_IDLE;
    endcase

    n.irq = '0;
    if (CFG.int_en && (r.perr.lerr || r.perr.herr)) begin
      n.irq[CFG.int_sel] = 1'b1;
    end

    if (!r.ctl.init_n) begin
      n.st   = pmb_pkg::ST_INIT;
      n.cnt  = 18'h00000;
      n.xack = 1'b0;
      n.oe_n = 1'b1;
      n.dout = 16'h0000;
      n.perr = pmb_pkg::PERR_RST;
      n.rd_pend = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      r <= '{st: pmb_pkg::ST_INIT, s1: '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
             s2: '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
             s3: '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
             ctl: '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
             oe_n: 1'b1, p_lo_n: 1'b1, p_hi_n: 1'b1, p_oe_n: 2'b11,
             perr: pmb_pkg::PERR_RST, default: '0};
    end else begin
      r <= n;
    end
  end

  assign DAT_OUT                  = r.dout;
  assign DAT_OE_N                 = r.oe_n;
  assign XACK_OUT                 = r.xack;
  assign INT_OUT                  = r.irq;
  assign OFFBOARD_REFRESH_REQUEST = r.ofref;
  assign LOW_BYTE_PARITY_N        = r.p_lo_n;
  assign HIGH_BYTE_PARITY_N       = r.p_hi_n;
  assign PAR_OE_N                 = r.p_oe_n;
  assign PERR_REG                 = r.perr;
endmodule : pmb_slave

// [verif/pmb_slave_monitor.sv]
// checker: port timing of the parity memory bus slave
`timescale 1ns/1ns
module pmb_slave_monitor (
  input wire logic              CORE_CLK,
  input wire logic              RST,
  input wire logic              INIT_N,
  input wire pmb_pkg::pmb_bus_t BUS_IN,
  input wire pmb_pkg::pmb_cfg_t CFG,
  input wire logic              DAT_OE_N,
  input wire logic              XACK_OUT,
  input wire logic [7:0]        INT_OUT,
  input wire logic [1:0]        PAR_OE_N,
  input wire logic [3:0]        PERR_REG
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  logic       cmd;
  logic [3:0] iow_age_r;
  assign cmd = BUS_IN.mrdc | BUS_IN.mwtc | BUS_IN.iorc | BUS_IN.iowc;
  // cycles since the last io write or init
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) iow_age_r <= 4'hF;
    else if (BUS_IN.iowc || !INIT_N) iow_age_r <= 4'h0;
    else if (iow_age_r != 4'hF) iow_age_r <= iow_age_r + 4'h1;
  end
  sequence s_quiet;
    !cmd [*6];
  endsequence
  sequence s_init_low;
    !INIT_N [*5];
  endsequence
  AST_ACK_CAUSE: assert property ($rose(XACK_OUT) |-> $past(cmd, 3))
    else $error("acknowledge without a held command");
  AST_ACK_DROP: assert property (s_quiet |=> !XACK_OUT && DAT_OE_N)
    else $error("acknowledge or data kept after command withdrawn");
  AST_READ_LEADS: assert property ($rose(XACK_OUT) && !DAT_OE_N |-> $past(!DAT_OE_N))
    else $error("read data not driven before acknowledge");
  AST_OE_NOT_WRITE: assert property (!DAT_OE_N |-> !BUS_IN.mwtc && !BUS_IN.iowc)
    else $error("data driven during a write");
  AST_WINDOW: assert property ($rose(XACK_OUT) && BUS_IN.mwtc |->
      BUS_IN.adr[23:22] == CFG.seg && BUS_IN.adr[21:10] >= CFG.low_kb[11:0]
      && BUS_IN.adr[21:10] <= CFG.high_kb[11:0])
    else $error("write acknowledged outside the window");
  AST_INIT_QUIET: assert property (s_init_low |=> !XACK_OUT)
    else $error("acknowledge during init");
  AST_INT_LINE: assert property (|INT_OUT |-> CFG.int_en && INT_OUT == 8'h01 << CFG.int_sel)
    else $error("wrong interrupt line");
  AST_INT_RAISE: assert property ($rose(|PERR_REG[3:2]) && CFG.int_en |-> ##[0:2] (|INT_OUT))
    else $error("parity error raised no interrupt");
  AST_PERR_KEEP: assert property ($fell(|PERR_REG[3:2]) |-> iow_age_r < 4'hA)
    else $error("error register cleared without io write");
  AST_PAR_DRV: assert property ((!PAR_OE_N[0] |-> CFG.par_lo_drv)
      and (!PAR_OE_N[1] |-> CFG.par_hi_drv))
    else $error("parity driven without its option");
endmodule : pmb_slave_monitor
////////////////////////////////////////////////////////////////////////
bind pmb_slave pmb_slave_monitor pmb_slave_monitor_i (
  .CORE_CLK(CORE_CLK), .RST(RST), .INIT_N(INIT_N), .BUS_IN(BUS_IN), .CFG(CFG),
  .DAT_OE_N(DAT_OE_N), .XACK_OUT(XACK_OUT), .INT_OUT(INT_OUT), .PAR_OE_N(PAR_OE_N),
  .PERR_REG(PERR_REG)
);

// [verif/pmb_master.sv]
// partner: bus master, one command at a time
`timescale 1ns/1ns
module pmb_master (
  input  wire logic         clk,
  input  wire logic         xack,
  input  wire logic [15:0]  dat_in,
  output pmb_pkg::pmb_bus_t bus
);
  initial bus = '0;
  task automatic xfer(input logic [3:0] c, input logic [23:0] a, input logic b,
                      input logic [15:0] w, output logic [15:0] r, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    r = 16'h0000;
    @(posedge clk);
    #1 bus = '{c[3], c[2], c[1], c[0], b, a, w};
    // hold all until acknowledge is sampled
    while (!ok && n < 40) begin
      @(posedge clk);
      #1;
      ok = xack;
      r = dat_in;
      n++;
    end
    bus = '0;
    while (xack && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (xack) ok = 1'b0;
  endtask : xfer
endmodule : pmb_master

// [verif/test_parity_memory_bus_slave.sv]
// bench: directed scenarios for the parity memory bus slave
`timescale 1ns/1ns
module test_parity_memory_bus_slave;
  localparam logic [3:0] RD = 4'h8, WR = 4'h4, IOW = 4'h1;
  logic core_clk, rst, init_n, onb_ref, offpar_n, xack, dat_oe_n, ofb_ref;
  logic [15:0] dat_out, r;
  logic [7:0] int_out;
  logic [3:0] perr, p;
  logic [1:0] par_oe_n;
  pmb_pkg::pmb_bus_t bus;
  pmb_pkg::pmb_cfg_t cfg;
  int fails, comparisons;
  pmb_slave #(.INIT_CYCLES(16)) pmb_slave_i (
    .CORE_CLK(core_clk), .RST(rst), .INIT_N(init_n), .BUS_IN(bus), .CFG(cfg),
    .ONBOARD_REFRESH_INDICATION(onb_ref), .OFFBOARD_PARITY_IN_N(offpar_n),
    .DAT_OUT(dat_out), .DAT_OE_N(dat_oe_n), .XACK_OUT(xack), .INT_OUT(int_out),
    .OFFBOARD_REFRESH_REQUEST(ofb_ref), .LOW_BYTE_PARITY_N(), .HIGH_BYTE_PARITY_N(),
    .PAR_OE_N(par_oe_n), .PERR_REG(perr));
  pmb_master pmb_master_i (.clk(core_clk), .xack(xack), .dat_in(dat_out), .bus(bus));
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic go(input logic [3:0] c, input logic [23:0] a, input logic b,
                    input logic [15:0] w, input logic exp_ok);
    logic ok;
    pmb_master_i.xfer(c, a, b, w, r, ok);
    check("acknowledge", {15'h0, exp_ok}, {15'h0, ok});
    if (ok !== exp_ok) give_verdict();
  endtask : go
  ////////////////////////////////////////////////////////////////////////
  task automatic t_io;
    go(IOW, 24'h000042, 1'b0, 16'h0000, 1'b1);
    check("error register", 16'h0000, {12'h0, perr});
    check("parity drive", 16'h0000, {14'h0, par_oe_n});
    go(IOW, 24'h000043, 1'b0, 16'h0000, 1'b0);
    go(IOW, 24'h000002, 1'b0, 16'h0000, 1'b0);
  endtask : t_io
  task automatic t_word;
    go(WR, 24'h001001, 1'b1, 16'hA55A, 1'b1);
    go(RD, 24'h001001, 1'b1, 16'h0000, 1'b1);
    check("word read", 16'hA55A, r);
    check("data released", 16'h0001, {15'h0, dat_oe_n});
    go(RD, 24'h001000, 1'b0, 16'h0000, 1'b1);
    check("even byte", 16'h005A, {8'h0, r[7:0]});
    go(RD, 24'h001001, 1'b0, 16'h0000, 1'b1);
    check("odd byte", 16'h00A5, {8'h0, r[7:0]});
  endtask : t_word
  task automatic t_bytes;
    go(WR, 24'h001FFE, 1'b0, 16'h0033, 1'b1);
    go(WR, 24'h001FFF, 1'b0, 16'h00CC, 1'b1);
    go(RD, 24'h001FFF, 1'b1, 16'h0000, 1'b1);
    check("merged word", 16'hCC33, r);
  endtask : t_bytes
  task automatic t_window;
    logic [23:0] outs [3];
    outs = '{24'h002000, 24'h000FFE, 24'h401000};
    foreach (outs[i]) go(WR, outs[i], 1'b1, 16'h1111, 1'b0);
  endtask : t_window
  task automatic t_parity;
    go(WR, 24'h001201, 1'b1, 16'h0F0F, 1'b1);
    offpar_n = 1'b0;
    go(RD, 24'h001201, 1'b1, 16'h0000, 1'b1);
    offpar_n = 1'b1;
    p = perr;
    check("error flag", 16'h0001, {15'h0, |perr[3:2]});
    check("interrupt", 16'h0008, {8'h0, int_out});
    go(RD, 24'h001001, 1'b1, 16'h0000, 1'b1);
    check("error held", {12'h0, p}, {12'h0, perr});
    go(IOW, 24'h000042, 1'b0, 16'hFFFF, 1'b1);
    check("error cleared", 16'h0000, {12'h0, perr});
    check("interrupt off", 16'h0000, {8'h0, int_out});
  endtask : t_parity
  task automatic t_refresh;
    logic e;
    for (int m = 0; m < 3; m++) begin
      for (int o = 0; o < 2; o++) begin
        cfg.ref_mode = pmb_pkg::pmb_ref_mode_t'(m);
        onb_ref = o[0];
        e = (m == 1) || (m == 2 && o == 0);
        repeat (6) @(posedge core_clk);
        #1 check("refresh request", {15'h0, e}, {15'h0, ofb_ref});
      end
    end
  endtask : t_refresh
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    init_n = 1'b0;
    onb_ref = 1'b0;
    offpar_n = 1'b1;
    fails = 0;
    comparisons = 0;
    cfg = '{2'h0, 14'h0004, 14'h0007, 2'h0, 5'h12, 1'b1, 3'h3,
            pmb_pkg::REF_ONBOARD, 1'b1, 1'b1, 1'b1, 1'b1};
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    go(WR, 24'h001001, 1'b1, 16'h1234, 1'b0);
    init_n = 1'b1;
    repeat (40) @(posedge core_clk);
    #1;
    t_io();
    t_word();
    t_bytes();
    t_window();
    t_parity();
    t_refresh();
    give_verdict();
  end
endmodule : test_parity_memory_bus_slave
